// ==== logic/pos_rx_pkg.sv ====
// constants and register map of the receive packet-over-sonet frame unit
// assumes an apb master and a byte stream with overhead positions flagged
// Contract
// - overhead bytes never reach the descrambler or the frame delineation.
// - optional self-synchronous x^43+1 descrambler ahead of delineation and destuffing.
// - frames are found on flag 0x7E; flags between packets are fill.
// - escape 0x7D is deleted and the next byte is xored with 0x20.
// - fcs over the whole destuffed frame, selectable 16-bit or 32-bit crc.
// - first received fcs bit is the highest-order polynomial coefficient.
// - packets failing fcs carry an error mark; the system discards them.
// - fifo full during a packet marks it errored and drops its remainder.
// - after overflow, writing resumes at next packet start with fill below restart level.
// - packet below minimum length is written but marked errored.
// - stripping on: too short for fcs plus one byte is dropped, counted minimum.
// - stripping off: one byte or more is written, still counted minimum.
// - packet above maximum length is errored; bytes past the maximum are dropped.
// - saturating 16-bit counters: fcs, minimum, maximum and aborted packets.
// - saturating 24-bit counter of error-free packets.
// - latch copies counters to holds and restarts live counts at 0 or 1.
// - fifo keeps read and write pointers and shows packet and byte availability.
// - fifo overrun gives a status bit and a maskable interrupt.
// - reading an empty fifo raises the underrun interrupt; reception goes on.
// - each system read carries a read-valid telling good data from bad.
package pos_rx_pkg;
  localparam int DEPTH = 256;
  localparam int CNT_N = 5;
  localparam int C_FCS = 0;
  localparam int C_MIN = 1;
  localparam int C_MAX = 2;
  localparam int C_ABT = 3;
  localparam int C_GOOD = 4;
  localparam logic [4:0][23:0] CNT_SAT = {24'hFFFFFF, {4{24'h00FFFF}}};
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RIL = 8'h04;
  localparam logic [7:0] A_MIN = 8'h08;
  localparam logic [7:0] A_MAX = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_MASK = 8'h14;
  localparam logic [7:0] A_LATCH = 8'h18;
  localparam logic [7:0] A_HOLD0 = 8'h1C;
  localparam int B_DESCR = 0;
  localparam int B_CRC32 = 1;
  localparam int B_STRIP = 2;
  localparam int B_OVR = 0;
  localparam int B_UDR = 1;
  localparam logic [2:0] CTRL_RST = 3'h7;
  localparam logic [7:0] RIL_RST = 8'h80;
  localparam logic [7:0] MIN_RST = 8'h04;
  localparam logic [15:0] MAX_RST = 16'h0600;
  localparam logic [7:0] FLAG_B = 8'h7E;
  localparam logic [7:0] ESC_B = 8'h7D;
  localparam logic [7:0] XMASK = 8'h20;
  localparam logic [15:0] P16 = 16'h8408;
  localparam logic [15:0] G16 = 16'hF0B8;
  localparam logic [31:0] P32 = 32'hEDB88320;
  localparam logic [31:0] G32 = 32'hDEBB20E3;
endpackage

// ==== logic/pos_rx_frame_unit.sv ====
// receive packet-over-sonet frame unit: descramble, delineate, destuff,
// fcs check, length policing, receive fifo and performance counters
// assumes payload bytes on i_clk with overhead positions flagged, apb master
`timescale 1ns/10ps
module pos_rx_frame_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // line byte stream
  input wire logic [7:0] i_rx_byte,
  input wire logic i_rx_byte_valid,
  input wire logic i_rx_overhead,
  // system read side
  input wire logic i_sys_read,
  output logic [7:0] o_rd_data,
  output logic o_rd_eop,
  output logic o_rd_err,
  output logic o_rx_read_valid,
  output logic o_pkt_avail,
  output logic o_byte_avail,
  // interrupt levels
  output logic o_fifo_overrun_irq,
  output logic o_fifo_underrun_irq
);
  typedef enum logic [1:0] {ST_HUNT, ST_IN, ST_DROP} frm_st_t;

  frm_st_t st_q;
  logic [2:0] ctrl_q;
  logic [7:0] ril_q, min_q;
  logic [15:0] max_q;
  logic [1:0] stat_q, mask_q;
  logic [42:0] scr_q, scr_d;
  logic [7:0] dsc, b1_q;
  logic v1_q;
  logic esc_q, maxerr_q, wrote_q, ovf_q;
  logic [15:0] len_q;
  logic [31:0] crc_q;
  logic [7:0] dl_q [4];
  logic [9:0] mem_q [pos_rx_pkg::DEPTH];
  logic [7:0] wp_q, rp_q;
  logic [8:0] cnt_q;
  logic [8:0] pkt_q;
  logic [23:0] live_q [pos_rx_pkg::CNT_N];
  logic [23:0] hold_q [pos_rx_pkg::CNT_N];
  logic [pos_rx_pkg::CNT_N-1:0] ev;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;

  function automatic logic [50:0] descr(input logic [42:0] h, input logic [7:0] d);
    logic [42:0] s;
    logic [7:0] o;
    s = h;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ s[42];
      s = {s[41:0], d[i]};
    end
    return {s, o};
  endfunction

  // lsb-first shifting makes the first fcs bit the top coefficient
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d,
                                          input logic w32);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      if (w32) begin
        r = {1'b0, r[31:1]} ^ (fb ? pos_rx_pkg::P32 : 32'h0);
      end else begin
        r = {17'h0, r[15:1]} ^ (fb ? {16'h0, pos_rx_pkg::P16} : 32'h0);
      end
    end
    return r;
  endfunction

  wire descr_en = ctrl_q[pos_rx_pkg::B_DESCR];
  wire w32 = ctrl_q[pos_rx_pkg::B_CRC32];
  wire strip = ctrl_q[pos_rx_pkg::B_STRIP];
  wire in_byte = i_rx_byte_valid && !i_rx_overhead;

  always_comb begin
    {scr_d, dsc} = descr(scr_q, i_rx_byte);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scr_q <= '0;
      b1_q <= 8'h00;
      v1_q <= 1'b0;
    end else begin
      v1_q <= in_byte;
      if (in_byte) begin
        scr_q <= scr_d;
        b1_q <= descr_en ? dsc : i_rx_byte;
      end
    end
  end

  // frame decode on the descrambled byte
  wire in_frm = v1_q && st_q == ST_IN;
  wire flag_ev = v1_q && b1_q == pos_rx_pkg::FLAG_B;
  wire abort_ev = in_frm && esc_q && flag_ev;
  wire end_ev = in_frm && !esc_q && flag_ev && len_q != 16'h0000;
  wire esc_ev = in_frm && !esc_q && b1_q == pos_rx_pkg::ESC_B;
  wire data_ev = in_frm && !flag_ev && !esc_ev;
  wire [7:0] dbyte = esc_q ? b1_q ^ pos_rx_pkg::XMASK : b1_q;
  wire [15:0] fcs_n = w32 ? 16'h0004 : 16'h0002;
  wire crc_ok = w32 ? crc_q == pos_rx_pkg::G32 : crc_q[15:0] == pos_rx_pkg::G16;
  wire mal = len_q < fcs_n + 16'h0001;
  wire min_bad = len_q < {8'h00, min_q};
  wire fcs_bad = !crc_ok;
  wire wr_full = cnt_q >= 9'(pos_rx_pkg::DEPTH - 1);
  // with stripping on, fcs bytes lag in a delay line so they never reach the fifo
  wire dat_want = data_ev && len_q < max_q && (!strip || len_q >= fcs_n);
  wire [7:0] wbyte = !strip ? dbyte : (w32 ? dl_q[3] : dl_q[1]);
  wire ovf_ev = dat_want && wr_full;
  wire trl_ev = (end_ev && !(strip && mal)) || (abort_ev && wrote_q) || ovf_ev;
  wire trl_err = ovf_ev || abort_ev || fcs_bad || min_bad || mal || maxerr_q;
  wire wr_en = (dat_want && !wr_full) || trl_ev;
  wire [9:0] wr_word = trl_ev ? {1'b1, trl_err, 8'h00} : {2'b00, wbyte};
  // a frame may only open with the reserved trailer slot still free
  wire resume_ok = cnt_q < 9'(pos_rx_pkg::DEPTH - 1) && (!ovf_q || cnt_q < {1'b0, ril_q});

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= ST_HUNT;
      ovf_q <= 1'b0;
    end else if (ovf_ev) begin
      st_q <= ST_DROP;
      ovf_q <= 1'b1;
    end else if (flag_ev) begin
      st_q <= resume_ok ? ST_IN : ST_DROP;
      if (resume_ok) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      esc_q <= 1'b0;
      len_q <= 16'h0000;
      crc_q <= 32'hFFFFFFFF;
      maxerr_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (flag_ev) begin
      esc_q <= 1'b0;
      len_q <= 16'h0000;
      crc_q <= w32 ? 32'hFFFFFFFF : 32'h0000FFFF;
      maxerr_q <= 1'b0;
      wrote_q <= 1'b0;
    end else if (esc_ev) begin
      esc_q <= 1'b1;
    end else if (data_ev) begin
      esc_q <= 1'b0;
      if (len_q != 16'hFFFF) begin
        len_q <= len_q + 16'h0001;
      end
      crc_q <= crc_upd(crc_q, dbyte, w32);
      if (len_q >= max_q) begin
        maxerr_q <= 1'b1;
      end
      if (wr_en) begin
        wrote_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        dl_q[i] <= 8'h00;
      end
    end else if (data_ev) begin
      dl_q[0] <= dbyte;
      for (int i = 1; i < 4; i++) begin
        dl_q[i] <= dl_q[i-1];
      end
    end
  end

  // receive fifo; one slot is kept back so an error trailer always fits
  wire rd_ok = i_sys_read && cnt_q != 9'h000;
  wire [9:0] rd_word = mem_q[rp_q];

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem_q[wp_q] <= wr_word;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_q <= 8'h00;
      rp_q <= 8'h00;
      cnt_q <= 9'h000;
      pkt_q <= 9'h000;
    end else begin
      wp_q <= wp_q + {7'h00, wr_en};
      rp_q <= rp_q + {7'h00, rd_ok};
      cnt_q <= cnt_q + {8'h00, wr_en} - {8'h00, rd_ok};
      pkt_q <= pkt_q + {8'h00, trl_ev} - {8'h00, rd_ok && rd_word[9]};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
      o_rd_eop <= 1'b0;
      o_rd_err <= 1'b0;
      o_rx_read_valid <= 1'b0;
      o_pkt_avail <= 1'b0;
      o_byte_avail <= 1'b0;
    end else begin
      o_rx_read_valid <= rd_ok;
      if (rd_ok) begin
        o_rd_data <= rd_word[7:0];
        o_rd_eop <= rd_word[9];
        o_rd_err <= rd_word[8];
      end
      o_pkt_avail <= pkt_q != 9'h000;
      o_byte_avail <= cnt_q != 9'h000;
    end
  end

  // performance counters; latch strobe comes from the apb write
  wire acc = i_psel && i_penable;
  wire done = acc && pready_q;
  wire latch_ev = done && i_pwrite && i_paddr == pos_rx_pkg::A_LATCH;

  always_comb begin
    ev = '0;
    ev[pos_rx_pkg::C_FCS] = end_ev && !mal && fcs_bad;
    ev[pos_rx_pkg::C_MIN] = end_ev && (min_bad || mal);
    ev[pos_rx_pkg::C_MAX] = end_ev && maxerr_q;
    ev[pos_rx_pkg::C_ABT] = abort_ev;
    ev[pos_rx_pkg::C_GOOD] = end_ev && !(fcs_bad || min_bad || mal || maxerr_q);
  end

  for (genvar g = 0; g < pos_rx_pkg::CNT_N; g++) begin : g_cnt
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        live_q[g] <= 24'h000000;
        hold_q[g] <= 24'h000000;
      end else if (latch_ev) begin
        hold_q[g] <= live_q[g];
        live_q[g] <= {23'h0, ev[g]};
      end else if (ev[g] && live_q[g] != pos_rx_pkg::CNT_SAT[g]) begin
        live_q[g] <= live_q[g] + 24'h000001;
      end
    end
  end

  // apb slave: one wait state so read data leaves a flop
  wire [7:0] hidx = i_paddr - pos_rx_pkg::A_HOLD0;
  wire hold_hit = i_paddr >= pos_rx_pkg::A_HOLD0 && hidx[7:2] < 6'(pos_rx_pkg::CNT_N)
                  && hidx[1:0] == 2'h0;
  logic [31:0] rdat;
  logic hit;

  always_comb begin
    rdat = 32'h00000000;
    hit = 1'b1;
    unique case (i_paddr)
      pos_rx_pkg::A_CTRL: rdat = {29'h0, ctrl_q};
      pos_rx_pkg::A_RIL: rdat = {24'h0, ril_q};
      pos_rx_pkg::A_MIN: rdat = {24'h0, min_q};
      pos_rx_pkg::A_MAX: rdat = {16'h0, max_q};
      pos_rx_pkg::A_STAT: rdat = {30'h0, stat_q};
      pos_rx_pkg::A_MASK: rdat = {30'h0, mask_q};
      pos_rx_pkg::A_LATCH: rdat = 32'h00000000;
      default: begin
        hit = hold_hit;
        rdat = hold_hit ? {8'h00, hold_q[hidx[4:2]]} : 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_q <= i_pwrite ? 32'h00000000 : rdat;
        pslverr_q <= !hit;
      end
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  wire wr_reg = done && i_pwrite;
  wire udr_ev = i_sys_read && cnt_q == 9'h000;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= pos_rx_pkg::CTRL_RST;
      ril_q <= pos_rx_pkg::RIL_RST;
      min_q <= pos_rx_pkg::MIN_RST;
      max_q <= pos_rx_pkg::MAX_RST;
      mask_q <= 2'h0;
    end else if (wr_reg) begin
      if (i_paddr == pos_rx_pkg::A_CTRL) ctrl_q <= i_pwdata[2:0];
      if (i_paddr == pos_rx_pkg::A_RIL) ril_q <= i_pwdata[7:0];
      if (i_paddr == pos_rx_pkg::A_MIN) min_q <= i_pwdata[7:0];
      if (i_paddr == pos_rx_pkg::A_MAX) max_q <= i_pwdata[15:0];
      if (i_paddr == pos_rx_pkg::A_MASK) mask_q <= i_pwdata[1:0];
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  wire [1:0] clr = (wr_reg && i_paddr == pos_rx_pkg::A_STAT) ? i_pwdata[1:0] : 2'h0;
  wire [1:0] set = {udr_ev, ovf_ev};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stat_q <= 2'h0;
      o_fifo_overrun_irq <= 1'b0;
      o_fifo_underrun_irq <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | set;
      o_fifo_overrun_irq <= stat_q[pos_rx_pkg::B_OVR] && mask_q[pos_rx_pkg::B_OVR];
      o_fifo_underrun_irq <= stat_q[pos_rx_pkg::B_UDR] && mask_q[pos_rx_pkg::B_UDR];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  AST_FLAG_NOT_DATA: assert property (
    (wr_en && !wr_word[9] && !strip) |-> !(b1_q == pos_rx_pkg::FLAG_B && !esc_q))
    else $error("flag byte written as data");
  AST_ESC_XOR: assert property (
    (wr_en && !wr_word[9] && !strip && esc_q) |-> wr_word[7:0] == (b1_q ^ 8'h20))
    else $error("escaped byte not restored");
  AST_OVF_DROP: assert property (
    ovf_ev |=> st_q == ST_DROP && stat_q[0] ##1 (st_q == ST_DROP || $past(flag_ev)))
    else $error("overflow did not drop frame");
  AST_RESUME_LEVEL: assert property (
    (ovf_q && flag_ev && cnt_q >= {1'b0, ril_q}) |=> st_q == ST_DROP && ovf_q)
    else $error("resumed above restart level");
  AST_MAX_CUT: assert property (
    (data_ev && len_q >= max_q) |-> !(wr_en && !wr_word[9]) ##1 maxerr_q)
    else $error("byte beyond maximum written");
  AST_SHORT_DROP: assert property (
    (end_ev && strip && mal) |-> !wr_en)
    else $error("malformed packet written");
  AST_LATCH_RESTART: assert property (
    (latch_ev && ev[4]) |=> live_q[4] == 24'h000001)
    else $error("live count lost an event");
  AST_GOOD_SAT: assert property (
    (live_q[4] == 24'hFFFFFF && !latch_ev) |=> live_q[4] == 24'hFFFFFF)
    else $error("good counter wrapped");
  AST_UNDERRUN: assert property (
    udr_ev |=> stat_q[1] && !o_rx_read_valid)
    else $error("underrun not flagged");
  AST_READ_VALID: assert property (
    rd_ok |=> o_rx_read_valid && o_rd_data == $past(rd_word[7:0]))
    else $error("read data not valid");
  AST_OVR_IRQ: assert property (
    (ovf_ev && mask_q[0] && !wr_reg) |-> ##2 o_fifo_overrun_irq)
    else $error("overrun interrupt missing");

  COV_GOOD: cover property (ev[4]);
  COV_OVF: cover property (ovf_ev ##[1:200] (flag_ev && st_q == ST_DROP));
  COV_ABORT: cover property (abort_ev);
  COV_UDR: cover property (udr_ev);
endmodule

// ==== verif/llink_reader.sv ====
// link-layer reader model on the receive fifo system side
// assumes registered fifo outputs and a one cycle lag on the avail flag
`timescale 1ns/10ps
module llink_reader (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // pace: 0 stall, 1 paced, 2 every cycle
  input wire logic [1:0] i_mode,
  // fifo read side
  input wire logic i_byte_avail,
  input wire logic i_rx_read_valid,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_eop,
  input wire logic i_rd_err,
  output logic o_sys_read
);
  logic gap_q;
  logic [9:0] got[$];
  int n_discard = 0;
  // paced reads skip two cycles so a stale avail flag never causes a read
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sys_read <= 1'b0;
      gap_q <= 1'b0;
    end else begin
      gap_q <= o_sys_read;
      o_sys_read <= (i_mode == 2'h2) ||
        (i_mode == 2'h1 && i_byte_avail && !o_sys_read && !gap_q);
      if (i_rx_read_valid) begin
        got.push_back({i_rd_eop, i_rd_err, i_rd_data});
        if (i_rd_eop && i_rd_err) n_discard++;
      end
    end
  end
endmodule

// ==== verif/pos_rx_frame_unit_test.sv ====
// self-checking bench of the receive frame unit with a reader model
// assumes reflected crc fcs sent low byte first, one wait state apb
`timescale 1ns/10ps
module pos_rx_frame_unit_test;
  typedef struct {int len; logic [7:0] base; bit bad; bit nofcs;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sys_read, rd_eop, rd_err, rd_valid;
  logic pkt_avail, byte_avail, ovr_irq, udr_irq;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] rd_data;
  logic rx_valid = 1'b0;
  logic rx_ovh = 1'b0;
  logic [1:0] mode = 2'h1;
  logic [42:0] hist = 43'h0;
  bit scr = 0;
  bit strip_on = 1;
  bit c32 = 0;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [9:0] exp_q[$];
  logic [31:0] r;
  logic e;
  row_t rows [5] = '{'{6, 8'h11, 0, 0}, '{5, 8'h7C, 0, 0}, '{4, 8'h20, 1, 0},
    '{1, 8'h30, 0, 0}, '{2, 8'h40, 0, 1}};

  always #5 clk = ~clk;

  pos_rx_frame_unit u_dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rx_byte(rx_byte), .i_rx_byte_valid(rx_valid),
    .i_rx_overhead(rx_ovh), .i_sys_read(sys_read), .o_rd_data(rd_data), .o_rd_eop(rd_eop),
    .o_rd_err(rd_err), .o_rx_read_valid(rd_valid), .o_pkt_avail(pkt_avail),
    .o_byte_avail(byte_avail), .o_fifo_overrun_irq(ovr_irq), .o_fifo_underrun_irq(udr_irq));

  llink_reader u_partner (.i_clk(clk), .i_sys_rst(rst), .i_mode(mode),
    .i_byte_avail(byte_avail), .i_rx_read_valid(rd_valid), .i_rd_data(rd_data),
    .i_rd_eop(rd_eop), .i_rd_err(rd_err), .o_sys_read(sys_read));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  // holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", {31'h0, pready}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk("register", r, want);
  endtask

  // scrambler history tracks every non-overhead line bit sent while scrambling
  task automatic put(input logic [7:0] b, input logic ovh);
    logic [7:0] o;
    o = b;
    if (scr && !ovh) begin
      for (int k = 7; k >= 0; k--) begin
        o[k] = b[k] ^ hist[42];
        hist = {hist[41:0], o[k]};
      end
    end
    @(posedge clk);
    rx_byte <= o;
    rx_valid <= 1'b1;
    rx_ovh <= ovh;
  endtask

  task automatic stuff(input logic [7:0] b);
    if (b == pos_rx_pkg::FLAG_B || b == pos_rx_pkg::ESC_B) begin
      put(pos_rx_pkg::ESC_B, 1'b0);
      put(b ^ pos_rx_pkg::XMASK, 1'b0);
    end else put(b, 1'b0);
  endtask

  task automatic send(input row_t rw);
    logic [7:0] q[$];
    logic [31:0] c;
    logic [31:0] p;
    int nf;
    bit err;
    nf = c32 ? 4 : 2;
    c = c32 ? 32'hFFFFFFFF : 32'h0000FFFF;
    p = c32 ? pos_rx_pkg::P32 : {16'h0, pos_rx_pkg::P16};
    for (int i = 0; i < rw.len; i++) q.push_back(rw.base + 8'(i));
    foreach (q[i]) begin
      c ^= {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ p : c >> 1;
    end
    c = ~c ^ {31'h0, rw.bad};
    if (!rw.nofcs) begin
      for (int k = 0; k < nf; k++) q.push_back(c[8*k +: 8]);
    end
    repeat (6) put(pos_rx_pkg::FLAG_B, 1'b0);
    foreach (q[i]) begin
      if (i == 2) put(pos_rx_pkg::FLAG_B, 1'b1);
      stuff(q[i]);
    end
    put(pos_rx_pkg::FLAG_B, 1'b0);
    @(posedge clk);
    rx_valid <= 1'b0;
    err = rw.bad || q.size() < int'(pos_rx_pkg::MIN_RST) || q.size() <= nf;
    if (!strip_on || q.size() > nf) begin
      for (int i = 0; i < q.size() - (strip_on ? nf : 0); i++) begin
        exp_q.push_back({2'b00, q[i]});
      end
      exp_q.push_back({1'b1, err, 8'h00});
    end
  endtask

  // waits for the expected word count, then a little longer for strays
  task automatic drain();
    int n;
    n = 0;
    while (u_partner.got.size() < exp_q.size() && n < 2000) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    chk("word count", 32'(u_partner.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < u_partner.got.size()) chk("word", 32'(u_partner.got[i]), 32'(exp_q[i]));
    exp_q.delete();
    u_partner.got.delete();
  endtask

  task automatic last_err();
    int n;
    n = 0;
    while ((u_partner.got.size() == 0 || !u_partner.got[$][9]) && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("trailer", 32'(u_partner.got[$]), 32'h300);
    exp_q.delete();
  endtask

  task automatic latch_chk(input logic [23:0] w [5]);
    apb(1'b1, pos_rx_pkg::A_LATCH, 32'h1);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, pos_rx_pkg::A_HOLD0 + 8'(4 * k), 32'h0);
      chk("counter hold", r, {8'h00, w[k]});
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(pos_rx_pkg::A_CTRL, {29'h0, pos_rx_pkg::CTRL_RST});
    rd(pos_rx_pkg::A_RIL, {24'h0, pos_rx_pkg::RIL_RST});
    rd(pos_rx_pkg::A_MIN, {24'h0, pos_rx_pkg::MIN_RST});
    rd(pos_rx_pkg::A_MAX, {16'h0, pos_rx_pkg::MAX_RST});
    rd(pos_rx_pkg::A_MASK, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, pos_rx_pkg::A_MASK, 32'h3);
    // descrambled first, before any raw byte, so both histories agree
    apb(1'b1, pos_rx_pkg::A_CTRL, 32'h5);
    scr = 1;
    send(rows[0]);
    drain();
    scr = 0;
    // crc16 with stripping, then crc32 with the fcs kept in the fifo
    for (int m = 0; m < 2; m++) begin
      strip_on = (m == 0);
      c32 = (m == 1);
      apb(1'b1, pos_rx_pkg::A_CTRL, m == 0 ? 32'h4 : 32'h2);
      foreach (rows[i]) begin
        send(rows[i]);
        drain();
      end
    end
    strip_on = 1;
    c32 = 0;
    apb(1'b1, pos_rx_pkg::A_CTRL, 32'h4);
    latch_chk('{24'h2, 24'h3, 24'h0, 24'h0, 24'h6});
    latch_chk('{24'h0, 24'h0, 24'h0, 24'h0, 24'h0});
    apb(1'b1, pos_rx_pkg::A_MAX, 32'h8);
    send('{10, 8'h50, 0, 0});
    last_err();
    chk("max cut", {31'h0, u_partner.got.size() <= 9}, 32'h1);
    u_partner.got.delete();
    apb(1'b1, pos_rx_pkg::A_MAX, 32'h600);
    repeat (6) put(pos_rx_pkg::FLAG_B, 1'b0);
    for (int i = 0; i < 5; i++) put(8'h61 + 8'(i), 1'b0);
    put(pos_rx_pkg::ESC_B, 1'b0);
    put(pos_rx_pkg::FLAG_B, 1'b0);
    put(pos_rx_pkg::FLAG_B, 1'b0);
    last_err();
    u_partner.got.delete();
    latch_chk('{24'h0, 24'h0, 24'h1, 24'h1, 24'h0});
    mode <= 2'h0;
    send('{300, 8'h00, 0, 0});
    send(rows[0]);
    exp_q.delete();
    chk("pkt avail", {31'h0, pkt_avail}, 32'h1);
    chk("byte avail", {31'h0, byte_avail}, 32'h1);
    rd(pos_rx_pkg::A_STAT, 32'h1);
    chk("overrun irq", {31'h0, ovr_irq}, 32'h1);
    mode <= 2'h1;
    for (int i = 0; i < 255; i++) exp_q.push_back({2'b00, 8'(i)});
    exp_q.push_back(10'h300);
    drain();
    send(rows[0]);
    drain();
    apb(1'b1, pos_rx_pkg::A_STAT, 32'h1);
    rd(pos_rx_pkg::A_STAT, 32'h0);
    chk("overrun irq", {31'h0, ovr_irq}, 32'h0);
    mode <= 2'h2;
    send(rows[1]);
    drain();
    mode <= 2'h1;
    rd(pos_rx_pkg::A_STAT, 32'h2);
    chk("underrun irq", {31'h0, udr_irq}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(pos_rx_pkg::A_STAT, 32'h0);
    chk("underrun irq", {31'h0, udr_irq}, 32'h0);
    chk("byte avail", {31'h0, byte_avail}, 32'h0);
    conclude();
  end
endmodule
